// [rtl/cbr_pkg.sv]
// constants, types and register map of the clock buffer management register bank
// assumes one clock domain; pins of the management bus are sampled on clock_i
// Functional notes
// [R1] first enable byte: bit k runs output k (0..7); 0 holds low, resets 1
// [R2] second enable byte: bit k runs output k+8; 0 holds low, resets 1
// [R3] override byte bit 3 picks mode source: 0 strap (reset), 1 bus bits
// [R4] override bits 2:1 give the mode while selected; both reset to 1
// [R5] mode readback bits 7:6 of byte 0 always show the strapped value
// [R6] host applies a warm reset before relying on a changed pll mode
// [R7] bytes 5 and 6 return fixed revision, maker and device codes; writes ignored
// [R8] byte 7 bits 4:0 set block read length; reset value 8
// [R9] reserved bytes 4, 8 and unused bits read zero and ignore writes
// [R10] register index steps by one after every data byte of a block
// [R11] block write: address, index, count, data bytes; every byte acknowledged
// [R12] block read: index, repeated start, read address; count then data returned
`default_nettype none

package cbr_pkg;
    localparam logic [7:0] IDX_STRAP = 8'h00;
    localparam logic [7:0] IDX_OE_LOW = 8'h01;
    localparam logic [7:0] IDX_OE_HIGH = 8'h02;
    localparam logic [7:0] IDX_OVERRIDE = 8'h03;
    localparam logic [7:0] IDX_RESERVED_A = 8'h04;
    localparam logic [7:0] IDX_REV_VENDOR = 8'h05;
    localparam logic [7:0] IDX_DEVICE = 8'h06;
    localparam logic [7:0] IDX_READ_COUNT = 8'h07;
    localparam logic [7:0] IDX_RESERVED_B = 8'h08;

    localparam logic [7:0] OE_RESET = 8'hFF;
    localparam int OVR_SEL_BIT = 3;
    localparam int OVR_MODE_HI = 2;
    localparam int OVR_MODE_LO = 1;
    localparam logic OVR_SEL_RESET = 1'b0;
    localparam logic [1:0] OVR_MODE_RESET = 2'h3;
    localparam int STRAP_LO = 6;
    localparam int COUNT_W = 5;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 5'h08;

    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h6C;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_RX_ACK,
        ST_TX,
        ST_TX_ACK
    } cbr_state_t;

    typedef enum logic [1:0] {
        ROLE_ADDR,
        ROLE_INDEX,
        ROLE_COUNT,
        ROLE_WDATA
    } cbr_role_t;
endpackage

`default_nettype wire

// [rtl/cbr_bus_if.sv]
// byte access path between the serial engine and the register bank
// assumes both ends sit on clock_i
`default_nettype none

interface cbr_bus_if;
    logic wr_en;
    logic [7:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] count_byte;

    modport engine (output wr_en, output idx, output wdata, input rdata, input count_byte);
    modport regs (input wr_en, input idx, input wdata, output rdata, output count_byte);
endinterface

`default_nettype wire

// [rtl/cbr_regs.sv]
// register bank: output enables, pll mode override, id codes, read length
// assumes the strap level is already latched outside and stable
`default_nettype none

module cbr_regs #(
    parameter logic [3:0] REV_CODE = 4'h2,    // arbitrary value
    parameter logic [3:0] VENDOR_CODE = 4'h5, // arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'h5A // arbitrary value
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // access path
    cbr_bus_if.regs bus,
    // pll mode
    input wire logic [1:0] pll_mode_strap_i,
    output logic pll_override_sel_o,
    output logic [1:0] pll_mode_o,
    // output enables
    output logic [15:0] out_on_o
);
    import cbr_pkg::*;

    logic [7:0] oe_low_q, oe_low_d;
    logic [7:0] oe_high_q, oe_high_d;
    logic sel_q, sel_d;
    logic [1:0] mode_q, mode_d;
    logic [1:0] pll_mode_q, pll_mode_d;
    logic [COUNT_W-1:0] count_q, count_d;

    always_comb begin
        oe_low_d = oe_low_q;
        oe_high_d = oe_high_q;
        sel_d = sel_q;
        mode_d = mode_q;
        count_d = count_q;
        if (bus.wr_en) begin
            if (bus.idx == IDX_OE_LOW) begin
                oe_low_d = bus.wdata; // [R1]
            end else if (bus.idx == IDX_OE_HIGH) begin
                oe_high_d = bus.wdata; // [R2]
            end else if (bus.idx == IDX_OVERRIDE) begin
                sel_d = bus.wdata[OVR_SEL_BIT]; // [R3]
                mode_d = bus.wdata[OVR_MODE_HI:OVR_MODE_LO]; // [R4]
            end else if (bus.idx == IDX_READ_COUNT) begin
                count_d = bus.wdata[COUNT_W-1:0]; // [R8]
            end
        end
        // id, strap readback and reserved bytes have no storage [R7] [R9]
        pll_mode_d = sel_q ? mode_q : pll_mode_strap_i; // [R3] [R4]
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            oe_low_q <= OE_RESET;
            oe_high_q <= OE_RESET;
            sel_q <= OVR_SEL_RESET;
            mode_q <= OVR_MODE_RESET;
            pll_mode_q <= OVR_MODE_RESET;
            count_q <= COUNT_RESET;
        end else begin
            oe_low_q <= oe_low_d;
            oe_high_q <= oe_high_d;
            sel_q <= sel_d;
            mode_q <= mode_d;
            pll_mode_q <= pll_mode_d;
            count_q <= count_d;
        end
    end

    always_comb begin
        bus.rdata = '0; // [R9]
        if (bus.idx == IDX_STRAP) begin
            bus.rdata[STRAP_LO+1:STRAP_LO] = pll_mode_strap_i; // [R5]
        end else if (bus.idx == IDX_OE_LOW) begin
            bus.rdata = oe_low_q;
        end else if (bus.idx == IDX_OE_HIGH) begin
            bus.rdata = oe_high_q;
        end else if (bus.idx == IDX_OVERRIDE) begin
            bus.rdata[OVR_SEL_BIT] = sel_q;
            bus.rdata[OVR_MODE_HI:OVR_MODE_LO] = mode_q;
        end else if (bus.idx == IDX_REV_VENDOR) begin
            bus.rdata = {REV_CODE, VENDOR_CODE}; // [R7]
        end else if (bus.idx == IDX_DEVICE) begin
            bus.rdata = DEVICE_CODE; // [R7]
        end else if (bus.idx == IDX_READ_COUNT) begin
            bus.rdata[COUNT_W-1:0] = count_q;
        end
    end

    assign bus.count_byte = {{(8-COUNT_W){1'b0}}, count_q};
    assign out_on_o = {oe_high_q, oe_low_q};
    assign pll_override_sel_o = sel_q;
    assign pll_mode_o = pll_mode_q;
endmodule

`default_nettype wire

// [rtl/cbr_top.sv]
// management bus slave of the clock buffer, serving indexed block transfers
// assumes scl/sda are already synchronous to clock_i; sda is open drain
`default_nettype none

module cbr_top #(
    parameter logic [6:0] DEV_ADDR = cbr_pkg::DEV_ADDR_DEFAULT,
    parameter logic [3:0] REV_CODE = 4'h2,    // arbitrary value
    parameter logic [3:0] VENDOR_CODE = 4'h5, // arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'h5A // arbitrary value
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // management bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    // pll mode
    input wire logic [1:0] pll_mode_strap_i,
    output logic pll_override_sel_o,
    output logic [1:0] pll_mode_o,
    // output enables
    output logic [15:0] out_on_o
);
    import cbr_pkg::*;

    cbr_bus_if bus ();

    cbr_regs #(
        .REV_CODE(REV_CODE),
        .VENDOR_CODE(VENDOR_CODE),
        .DEVICE_CODE(DEVICE_CODE)
    ) u_regs (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .bus(bus),
        .pll_mode_strap_i(pll_mode_strap_i),
        .pll_override_sel_o(pll_override_sel_o),
        .pll_mode_o(pll_mode_o),
        .out_on_o(out_on_o)
    );

    cbr_state_t state_q, state_d;
    cbr_role_t role_q, role_d;
    logic [3:0] bitcnt_q, bitcnt_d;
    logic [7:0] shreg_q, shreg_d;
    logic [7:0] idx_q, idx_d;
    logic rd_q, rd_d;
    logic pull_q, pull_d;
    logic scl_q, sda_q;
    logic wr_en;
    logic scl_rise, scl_fall, start_seen, stop_seen;

    always_comb begin
        scl_rise = scl_i & ~scl_q;
        scl_fall = ~scl_i & scl_q;
        start_seen = scl_i & scl_q & sda_q & ~sda_i;
        stop_seen = scl_i & scl_q & ~sda_q & sda_i;
    end

    always_comb begin
        state_d = state_q;
        role_d = role_q;
        bitcnt_d = bitcnt_q;
        shreg_d = shreg_q;
        idx_d = idx_q;
        rd_d = rd_q;
        pull_d = pull_q;
        wr_en = 1'b0;
        if (start_seen) begin
            // start and repeated start both reopen the address phase
            state_d = ST_RX;
            role_d = ROLE_ADDR;
            bitcnt_d = '0;
            pull_d = 1'b0;
        end else if (stop_seen) begin
            state_d = ST_IDLE;
            pull_d = 1'b0;
        end else begin
            case (state_q)
                ST_RX: begin
                    if (scl_rise) begin
                        shreg_d = {shreg_q[6:0], sda_i};
                        bitcnt_d = 4'(bitcnt_q + 4'h1);
                    end else if (scl_fall && bitcnt_q == BITS_PER_BYTE) begin
                        bitcnt_d = '0;
                        state_d = ST_RX_ACK;
                        pull_d = 1'b1; // [R11]
                        case (role_q)
                            ROLE_ADDR: begin
                                if (shreg_q[7:1] != DEV_ADDR) begin
                                    state_d = ST_IDLE;
                                    pull_d = 1'b0;
                                end else begin
                                    rd_d = shreg_q[0];
                                    role_d = ROLE_INDEX;
                                end
                            end
                            ROLE_INDEX: begin
                                idx_d = shreg_q; // [R10]
                                role_d = ROLE_COUNT;
                            end
                            ROLE_COUNT: begin
                                // length is not enforced; stop ends the block
                                role_d = ROLE_WDATA;
                            end
                            default: begin
                                wr_en = 1'b1; // [R11]
                                idx_d = 8'(idx_q + 8'h01); // [R10]
                            end
                        endcase
                    end
                end
                ST_RX_ACK: begin
                    if (scl_fall) begin
                        if (rd_q) begin
                            // read address taken: count byte goes first
                            state_d = ST_TX;
                            shreg_d = bus.count_byte; // [R12]
                            pull_d = ~bus.count_byte[7];
                        end else begin
                            state_d = ST_RX;
                            pull_d = 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bitcnt_q == LAST_BIT) begin
                            state_d = ST_TX_ACK;
                            bitcnt_d = '0;
                            pull_d = 1'b0;
                        end else begin
                            shreg_d = {shreg_q[6:0], 1'b0};
                            bitcnt_d = 4'(bitcnt_q + 4'h1);
                            pull_d = ~shreg_q[6];
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise && sda_i) begin
                        state_d = ST_IDLE; // [R12]
                    end else if (scl_fall) begin
                        state_d = ST_TX;
                        shreg_d = bus.rdata; // [R12]
                        pull_d = ~bus.rdata[7];
                        idx_d = 8'(idx_q + 8'h01); // [R10]
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= ST_IDLE;
            role_q <= ROLE_ADDR;
            bitcnt_q <= '0;
            shreg_q <= '0;
            idx_q <= '0;
            rd_q <= 1'b0;
            pull_q <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            state_q <= state_d;
            role_q <= role_d;
            bitcnt_q <= bitcnt_d;
            shreg_q <= shreg_d;
            idx_q <= idx_d;
            rd_q <= rd_d;
            pull_q <= pull_d;
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    assign bus.wr_en = wr_en;
    assign bus.idx = idx_q;
    assign bus.wdata = shreg_q;
    assign sda_o = 1'b0;
    assign sda_oe_n_o = ~pull_q;
endmodule

`default_nettype wire

// [bench/cbr_top_checker.sv]
// assertions on the management bus pins and control outputs of cbr_top
// assumes sda_i is the resolved wire with a pull-up
`default_nettype none
module cbr_top_checker (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n_o,
    input wire logic [1:0] pll_mode_strap_i,
    input wire logic pll_override_sel_o,
    input wire logic [1:0] pll_mode_o,
    input wire logic [15:0] out_on_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    sequence drive_start;
        $fell(sda_oe_n_o);
    endsequence
    sequence drive_hold;
        !sda_oe_n_o [*4];
    endsequence
    reset_values_a: assert property ($rose(arst_n_i) |-> out_on_o == 16'hFFFF
        && !pll_override_sel_o && pll_mode_o == 2'h3) else $error("bad state after reset");
    open_drain_a: assert property (sda_o == 1'b0) else $error("sda driven high");
    strap_follow_a: assert property ($past(arst_n_i) && !pll_override_sel_o
        && !$past(pll_override_sel_o) && $stable(pll_mode_strap_i)
        |-> pll_mode_o == pll_mode_strap_i) else $error("mode not from strap");
    cfg_quiet_a: assert property ($past(scl_i)
        |-> $stable({out_on_o, pll_override_sel_o})) else $error("control moved, scl high");
    mode_quiet_a: assert property (pll_override_sel_o && $past(pll_override_sel_o)
        && $past(scl_i) |-> $stable(pll_mode_o)) else $error("mode moved, scl high");
    oe_edge_a: assert property ($changed(sda_oe_n_o) |-> !$past(scl_i))
        else $error("sda drive moved, scl high");
    ack_hold_a: assert property (drive_start |-> drive_hold)
        else $error("sda drive too short");
    start_free_a: assert property (scl_i && $past(scl_i) && $fell(sda_i) |-> sda_oe_n_o)
        else $error("sda driven at start");
endmodule
bind cbr_top cbr_top_checker chk_u (.clock_i(clock_i), .arst_n_i(arst_n_i), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .pll_mode_strap_i(pll_mode_strap_i),
    .pll_override_sel_o(pll_override_sel_o), .pll_mode_o(pll_mode_o), .out_on_o(out_on_o));
`default_nettype wire

// [bench/cbr_host.sv]
// bus host model: bit, byte and indexed block transfers
// assumes sda_w is the resolved wire with a pull-up
`default_nettype none
module cbr_host #(
    parameter logic [6:0] DEV_ADDR = cbr_pkg::DEV_ADDR_DEFAULT
) (
    input wire logic clock_i,
    input wire logic sda_w,
    output var logic scl_o,
    output var logic sda_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {scl_o, sda_o} = 2'b11;
    task automatic idle(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    // one scl period: sda moves only while scl is low, read at mid high
    task automatic xfer_bit(input logic b, output logic r);
        scl_o = 1'b0;
        idle(2);
        sda_o = b;
        idle(2);
        scl_o = 1'b1;
        idle(2);
        r = sda_w;
        idle(2);
    endtask
    // start when lvl is 1, stop when lvl is 0: sda flips while scl is high
    task automatic cond(input logic lvl);
        scl_o = 1'b0;
        idle(2);
        sda_o = lvl;
        idle(2);
        scl_o = 1'b1;
        idle(3);
        sda_o = !lvl;
        idle(3);
    endtask
    task automatic xfer_byte(input logic [7:0] b, input logic last, output logic [7:0] r,
                             output logic a);
        for (int i = 7; i >= 0; i--) xfer_bit(b[i], r[i]);
        xfer_bit(last, a);
    endtask
    task automatic wb(input logic [7:0] b, inout int nak);
        logic [7:0] r;
        logic a;
        xfer_byte(b, 1'b1, r, a);
        nak += (a !== 1'b0) ? 1 : 0;
    endtask
    task automatic blk_write(input logic [7:0] idx, input logic [7:0] d[$], output int nak);
        nak = 0;
        cond(1'b1);
        wb({DEV_ADDR, 1'b0}, nak);
        wb(idx, nak);
        wb(8'(d.size()), nak);
        foreach (d[i]) wb(d[i], nak);
        cond(1'b0);
    endtask
    task automatic blk_read(input logic [7:0] idx, input int n, output logic [7:0] q[$],
                            output int nak);
        logic [7:0] r;
        logic a;
        nak = 0;
        q = {};
        cond(1'b1);
        wb({DEV_ADDR, 1'b0}, nak);
        wb(idx, nak);
        cond(1'b1);
        wb({DEV_ADDR, 1'b1}, nak);
        for (int i = 0; i <= n; i++) begin
            xfer_byte(8'hFF, 1'(i == n), r, a);
            q.push_back(r);
        end
        cond(1'b0);
    endtask
endmodule
`default_nettype wire

// [bench/testbench.sv]
// random block writes to the register bank, each checked by read-back
// assumes the host model drives the pins and the wire has a pull-up
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import cbr_pkg::*;
    localparam logic [3:0] REV = 4'h3; // arbitrary value
    localparam logic [3:0] VEN = 4'h9; // arbitrary value
    localparam logic [7:0] DEVC = 8'h6E; // arbitrary value
    logic clock_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [1:0] strap = 2'h0;
    logic scl, sda_h, sda_o, sda_oe_n, sel;
    logic [1:0] mode;
    logic [15:0] on;
    wire logic sda_w = sda_h & (sda_oe_n | sda_o);
    logic [7:0] m [0:8];
    logic [7:0] q[$];
    logic [7:0] d[$];
    logic [7:0] idx;
    int fails = 0;
    int n_compared = 0;
    int cyc = 0;
    int nak;
    always #4 clock_i = ~clock_i;
    cbr_host host_u (.clock_i(clock_i), .sda_w(sda_w), .scl_o(scl), .sda_o(sda_h));
    cbr_top #(.REV_CODE(REV), .VENDOR_CODE(VEN), .DEVICE_CODE(DEVC)) dut_u (
        .clock_i(clock_i), .arst_n_i(arst_n_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_n_o(sda_oe_n), .pll_mode_strap_i(strap), .pll_override_sel_o(sel),
        .pll_mode_o(mode), .out_on_o(on));
    task automatic test_done();
        if (fails == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic void model_reset();
        m = '{8'h00, OE_RESET, OE_RESET, {4'h0, OVR_SEL_RESET, OVR_MODE_RESET, 1'b0}, 8'h00,
              {REV, VEN}, DEVC, {3'h0, COUNT_RESET}, 8'h00};
        m[0] = {strap, 6'h00};
    endfunction
    function automatic logic [7:0] wmask(input int i);
        case (i)
            1, 2: return 8'hFF;
            3: return 8'h0E;
            7: return 8'h1F;
            default: return 8'h00;
        endcase
    endfunction
    function automatic logic [7:0] ex(input int i);
        return (i <= 8) ? m[i] : 8'h00;
    endfunction
    task automatic write_blk();
        host_u.blk_write(idx, d, nak);
        chk("write acks", 16'h0000, 16'(nak));
        foreach (d[i]) begin
            if (idx + i <= 8) begin
                m[idx + i] = (m[idx + i] & ~wmask(idx + i)) | (d[i] & wmask(idx + i));
            end
        end
    endtask
    task automatic check_from(input logic [7:0] s, input int n);
        host_u.blk_read(s, n, q, nak);
        chk("read acks", 16'h0000, 16'(nak));
        chk("count byte", {8'h00, m[7]}, {8'h00, q[0]});
        for (int i = 0; i < n; i++) begin
            chk("data byte", {8'(s + i), ex(s + i)}, {8'(s + i), q[i + 1]});
        end
        chk("out_on", {m[2], m[1]}, on);
        chk("sel mode", 16'({m[3][3], m[3][3] ? m[3][2:1] : strap}), 16'({sel, mode}));
    endtask
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fails++;
            test_done();
        end
    end
    initial begin
        void'($urandom(32'ha820_bf80));
        strap = 2'($urandom_range(3));
        repeat (8) @(negedge clock_i);
        arst_n_i = 1'b1;
        repeat (2) @(negedge clock_i);
        model_reset();
        check_from(8'h00, 9);
        nak = 0;
        host_u.cond(1'b1);
        host_u.wb({DEV_ADDR_DEFAULT ^ 7'h01, 1'b0}, nak);
        host_u.cond(1'b0);
        chk("foreign address", 16'h0001, 16'(nak));
        idx = IDX_STRAP;
        d = {};
        repeat (9) d.push_back(8'hFF);
        write_blk();
        check_from(8'h00, 9);
        repeat (20) begin
            idx = 8'($urandom_range(9));
            d = {};
            repeat ($urandom_range(4, 1)) d.push_back(8'($urandom));
            write_blk();
            check_from(8'($urandom_range(8)), $urandom_range(10, 1));
        end
        idx = IDX_OVERRIDE;
        d = {{4'h0, 1'b1, ~strap, 1'b1}};
        write_blk();
        check_from(8'h00, 9);
        arst_n_i = 1'b0;
        repeat (2) @(negedge clock_i);
        arst_n_i = 1'b1;
        repeat (2) @(negedge clock_i);
        model_reset();
        check_from(8'h00, 9);
        test_done();
    end
endmodule
`default_nettype wire
